// ==== mwg_can_model.sv ====
// can network stand-in: drains transmit words and injects received frames
// assumes the gateway's valid/ready transmit port and a single clock
`timescale 1ns/1ps
`default_nettype none
module mwg_can_model (
  // clock
  input  wire logic        clk_in,
  // transmit side
  input  wire logic        tx_valid_in,
  input  wire logic [15:0] tx_data_in,
  output logic             tx_ready_out,
  input  wire logic        stall_in,
  // receive side
  output logic             rx_valid_out,
  output logic [28:0]      rx_id_out,
  output logic             rx_ext_out,
  output logic             rx_rtr_out,
  output logic [3:0]       rx_dlc_out,
  output logic [63:0]      rx_data_out
);
  logic [15:0] seen[$];
  logic        rdy;

  // idle levels at time zero
  initial begin
    tx_ready_out = 1'b0;
    rx_valid_out = 1'b0;
    {rx_id_out, rx_ext_out, rx_rtr_out, rx_dlc_out, rx_data_out} = '0;
  end

  // ready wanders when not stalled, so drains are both prompt and slow
  always @(posedge clk_in) begin
    if (tx_valid_in && tx_ready_out)
      seen.push_back(tx_data_in);
    rdy = !stall_in && ($urandom % 3 != 0);
    #1 tx_ready_out = rdy;
  end

  // one-cycle frame; fields are inverted afterwards so stale values never look valid
  task automatic send(input logic [28:0] id, input logic ext, input logic rtr, input logic [3:0] dlc,
                      input logic [63:0] d);
    @(posedge clk_in);
    #1;
    {rx_id_out, rx_ext_out, rx_rtr_out, rx_dlc_out, rx_data_out} = {id, ext, rtr, dlc, d};
    rx_valid_out = 1'b1;
    @(posedge clk_in);
    #1;
    rx_valid_out = 1'b0;
    {rx_id_out, rx_ext_out, rx_rtr_out, rx_dlc_out, rx_data_out} = ~{id, ext, rtr, dlc, d};
  endtask : send
endmodule : mwg_can_model
`default_nettype wire

// ==== mwg_fifo.sv ====
// fifo between the frame sequencer and the can controller
// assumes one clock, synchronous active-high reset
`timescale 1ns/1ps
`default_nettype none
module mwg_fifo #(
  parameter int W     = 16,
  parameter int DEPTH = 16
) (
  // clock and reset
  input  wire logic         clk_in,
  input  wire logic         reset_in,
  // fill side
  input  wire logic         in_valid_in,
  input  wire logic [W-1:0] in_data_in,
  output logic              in_ready_out,
  // drain side
  output logic              out_valid_out,
  output logic [W-1:0]      out_data_out,
  input  wire logic         out_ready_in
);
  localparam int AW = $clog2(DEPTH);

  typedef struct packed {
    logic [DEPTH-1:0][W-1:0] mem;
    logic [AW-1:0]           wr;
    logic [AW-1:0]           rd;
    logic [AW:0]             cnt;
    logic                    has_data;
    logic [W-1:0]            head;
  } mwg_fifo_st_t;

  mwg_fifo_st_t st_reg;
  mwg_fifo_st_t st_next;
  logic         push;
  logic         pop;

  // full comes from the registered count; the drain side sees flops only, so it can leave the block directly
  assign in_ready_out  = (st_reg.cnt != (AW+1)'(DEPTH));
  assign out_valid_out = st_reg.has_data;
  assign out_data_out  = st_reg.head;
  assign push          = in_valid_in && in_ready_out;
  assign pop           = out_valid_out && out_ready_in;

  // pointer and count update
  always_comb begin
    st_next = st_reg;
    if (push) begin
      st_next.mem[st_reg.wr] = in_data_in;
      st_next.wr             = st_reg.wr + AW'(1);
    end
    if (pop) begin
      st_next.rd = st_reg.rd + AW'(1);
    end
    if (push && !pop) begin
      st_next.cnt = st_reg.cnt + (AW+1)'(1);
    end else if (pop && !push) begin
      st_next.cnt = st_reg.cnt - (AW+1)'(1);
    end
    // registered copies of empty and head word, taken from the next state
    st_next.has_data = (st_next.cnt != '0);
    st_next.head     = st_next.mem[st_next.rd];
  end

  // state register
  always_ff @(posedge clk_in) begin
    if (reset_in) begin
      st_reg <= '0;
    end else begin
      st_reg <= st_next;
    end
  end
endmodule : mwg_fifo
`default_nettype wire

// ==== mwg_gateway.sv ====
// word-register to can frame gateway: output words, transmit queue, specific-message field
// assumes requests arrive decoded (function, address, value or count); can controller outside
// What this block does
// - word 4 holds payload bytes three and four, written singly.
// - word 5 holds payload bytes five and six, written singly.
// - word 6 holds payload bytes seven and eight, written singly.
// - a write to word 7 while no frame is being queued queues the stored words as a frame.
// - rewriting word 7 resends using the stored words unchanged.
// - received identifiers matching the ten-entry list are stored in the field.
// - a matching frame overwrites its slot, keeping the latest.
// - function 04 returns the specific-message field contents.
// - busy exception on transmit overrun or reading an empty slot.
`timescale 1ns/1ps
`default_nettype none
module mwg_gateway
  import mwg_pkg::*;
(
  // clock and reset
  input  wire logic                        clk_in,
  input  wire logic                        reset_in,
  // decoded request
  input  wire logic                        req_valid_in,
  input  wire logic [7:0]                  req_func_in,
  input  wire logic [15:0]                 req_addr_in,
  input  wire logic [15:0]                 req_data_in,
  output logic                             req_ready_out,
  // answer
  output logic                             resp_valid_out,
  output logic                             resp_exc_out,
  output logic                             resp_last_out,
  output logic [15:0]                      resp_data_out,
  // frames toward the can controller
  output logic                             can_tx_valid_out,
  output logic [WORD_W-1:0]                can_tx_data_out,
  input  wire logic                        can_tx_ready_in,
  // received frames
  input  wire logic                        can_rx_valid_in,
  input  wire logic [ID_W-1:0]             can_rx_id_in,
  input  wire logic                        can_rx_ext_in,
  input  wire logic                        can_rx_rtr_in,
  input  wire logic [3:0]                  can_rx_dlc_in,
  input  wire logic [63:0]                 can_rx_data_in,
  // specific identifier list
  input  wire logic [SPEC_SLOTS-1:0]       id_list_en_in,
  input  wire logic [SPEC_SLOTS-1:0]       id_list_ext_in,
  input  wire logic [SPEC_SLOTS*ID_W-1:0]  id_list_in
);
  typedef enum logic [0:0] {
    MWG_IDLE = 1'b0,
    MWG_READ = 1'b1
  } mwg_mode_t;

  typedef struct packed {
    mwg_mode_t                                  mode;
    logic [TX_REGS-1:0][WORD_W-1:0]             tx_words;
    logic                                       push_busy;
    logic [2:0]                                 push_idx;
    logic                                       req_ready;
    logic                                       resp_valid;
    logic                                       resp_exc;
    logic                                       resp_last;
    logic [15:0]                                resp_data;
    logic [3:0]                                 rd_slot;
    logic [3:0]                                 rd_word;
    logic [6:0]                                 rd_left;
    logic [SPEC_SLOTS-1:0]                      slot_valid;
    logic [SPEC_SLOTS-1:0][SLOT_WORDS-1:0][15:0] slot_words;
    logic [7:0]                                 tick_div;
    logic [31:0]                                stamp;
  } mwg_st_t;

  mwg_st_t               st_reg;
  mwg_st_t               st_next;
  logic [SPEC_SLOTS-1:0] rx_hit;
  logic                  fifo_ready;
  logic                  take;
  logic                  count_ok;
  logic                  slot_empty;

  assign take = req_valid_in && st_reg.req_ready;

  // identifier compare, one comparator per list entry
  generate
    for (genvar g = 0; g < SPEC_SLOTS; g++) begin : g_match
      assign rx_hit[g] = can_rx_valid_in && id_list_en_in[g] && (id_list_ext_in[g] == can_rx_ext_in)
                         && (id_list_in[g*ID_W +: ID_W] == can_rx_id_in);
    end
  endgenerate

  // count must be a nonzero multiple of nine, at most ninety; every slot covered must hold a frame
  always_comb begin
    count_ok   = 1'b0;
    slot_empty = 1'b0;
    for (int k = 1; k <= SPEC_SLOTS; k++) begin
      if (req_data_in == 16'(k * SLOT_WORDS)) count_ok = 1'b1;
    end
    for (int k = 0; k < SPEC_SLOTS; k++) begin
      if ((16'(k * SLOT_WORDS) < req_data_in) && !st_reg.slot_valid[k]) slot_empty = 1'b1;
    end
  end

  // request handling, sequencer, receive capture and timestamp
  always_comb begin
    st_next            = st_reg;
    st_next.resp_valid = 1'b0;
    st_next.resp_exc   = 1'b0;
    st_next.resp_last  = 1'b0;
    // microsecond timestamp from a one-cycle tick enable
    if (st_reg.tick_div == 8'(TICK_CYCLES - 1)) begin
      st_next.tick_div = 8'h00;
      st_next.stamp    = st_reg.stamp + 32'h0000_0001;
    end else begin
      st_next.tick_div = st_reg.tick_div + 8'h01;
    end
    // sequencer walks words 0..6 into the queue, stalling on a full queue
    if (st_reg.push_busy && fifo_ready) begin
      if (st_reg.push_idx == 3'(FRAME_WORDS - 1)) begin
        st_next.push_busy = 1'b0;
      end
      st_next.push_idx = st_reg.push_idx + 3'h1;
    end
    unique case (st_reg.mode)
      MWG_IDLE: begin
        if (take) begin
          st_next.resp_valid = 1'b1;
          st_next.resp_last  = 1'b1;
          st_next.resp_data  = req_data_in;
          if (req_func_in == FN_WRITE_SINGLE) begin
            if (req_addr_in > OFS_TX_TRIGGER) begin
              st_next.resp_exc  = 1'b1;
              st_next.resp_data = {8'h00, EXC_ILL_ADDR};
            end else if (req_addr_in == OFS_TX_TRIGGER) begin
              // the written value is not kept; stored words are reused for a resend
              if (st_reg.push_busy) begin
                st_next.resp_exc  = 1'b1;
                st_next.resp_data = {8'h00, EXC_BUSY};
              end else begin
                st_next.push_busy = 1'b1;
                st_next.push_idx  = 3'h0;
              end
            end else begin
              // payload words are stored as written: upper byte is the earlier payload byte
              st_next.tx_words[req_addr_in[2:0]] = req_data_in;
            end
          end else if (req_func_in == FN_READ_INPUT) begin
            if (req_addr_in != SPEC_BASE) begin
              st_next.resp_exc  = 1'b1;
              st_next.resp_data = {8'h00, EXC_ILL_ADDR};
            end else if (!count_ok) begin
              st_next.resp_exc  = 1'b1;
              st_next.resp_data = {8'h00, EXC_ILL_VALUE};
            end else if (slot_empty) begin
              st_next.resp_exc  = 1'b1;
              st_next.resp_data = {8'h00, EXC_BUSY};
            end else begin
              // first word goes out now, the rest one per cycle
              st_next.resp_data = st_reg.slot_words[0][0];
              st_next.resp_last = (req_data_in == 16'(1));
              st_next.rd_slot   = 4'h0;
              st_next.rd_word   = 4'h1;
              st_next.rd_left   = 7'(req_data_in - 16'h0001);
              st_next.mode      = MWG_READ;
              st_next.req_ready = 1'b0;
            end
          end else begin
            st_next.resp_exc  = 1'b1;
            st_next.resp_data = {8'h00, EXC_ILL_FUNC};
          end
        end
      end
      MWG_READ: begin
        st_next.resp_valid = 1'b1;
        st_next.resp_data  = st_reg.slot_words[st_reg.rd_slot][st_reg.rd_word];
        st_next.rd_left    = st_reg.rd_left - 7'h01;
        if (st_reg.rd_word == 4'(SLOT_WORDS - 1)) begin
          st_next.rd_word = 4'h0;
          st_next.rd_slot = st_reg.rd_slot + 4'h1;
        end else begin
          st_next.rd_word = st_reg.rd_word + 4'h1;
        end
        if (st_reg.rd_left == 7'h01) begin
          st_next.resp_last = 1'b1;
          st_next.mode      = MWG_IDLE;
          st_next.req_ready = 1'b1;
        end
      end
    endcase
    // a new match always overwrites the slot so the latest frame is kept
    for (int s = 0; s < SPEC_SLOTS; s++) begin
      if (rx_hit[s]) begin
        st_next.slot_valid[s]    = 1'b1;
        st_next.slot_words[s][0] = {10'h000, can_rx_ext_in, can_rx_rtr_in, can_rx_dlc_in};
        st_next.slot_words[s][1] = {3'h0, can_rx_id_in[28:16]};
        st_next.slot_words[s][2] = can_rx_id_in[15:0];
        st_next.slot_words[s][3] = can_rx_data_in[63:48];
        st_next.slot_words[s][4] = can_rx_data_in[47:32];
        st_next.slot_words[s][5] = can_rx_data_in[31:16];
        st_next.slot_words[s][6] = can_rx_data_in[15:0];
        st_next.slot_words[s][7] = st_reg.stamp[31:16];
        st_next.slot_words[s][8] = st_reg.stamp[15:0];
      end
    end
  end

  // state register
  always_ff @(posedge clk_in) begin
    if (reset_in) begin
      st_reg           <= '0;
      st_reg.mode      <= MWG_IDLE;
      st_reg.req_ready <= 1'b1;
    end else begin
      st_reg <= st_next;
    end
  end

  assign req_ready_out  = st_reg.req_ready;
  assign resp_valid_out = st_reg.resp_valid;
  assign resp_exc_out   = st_reg.resp_exc;
  assign resp_last_out  = st_reg.resp_last;
  assign resp_data_out  = st_reg.resp_data;

  // transmit queue; its ready stalls the sequencer
  mwg_fifo #(
    .W     (WORD_W),
    .DEPTH (FIFO_DEPTH)
  ) u_tx_fifo (
    .clk_in        (clk_in),
    .reset_in      (reset_in),
    .in_valid_in   (st_reg.push_busy),
    .in_data_in    (st_reg.tx_words[st_reg.push_idx]),
    .in_ready_out  (fifo_ready),
    .out_valid_out (can_tx_valid_out),
    .out_data_out  (can_tx_data_out),
    .out_ready_in  (can_tx_ready_in)
  );

  // checks
  sequence s_write(logic [15:0] a);
    take && req_func_in == FN_WRITE_SINGLE && req_addr_in == a;
  endsequence
  sequence s_trigger_free;
    s_write(OFS_TX_TRIGGER) ##0 !st_reg.push_busy;
  endsequence

  a_word4_store: assert property (@(posedge clk_in) disable iff (reset_in)
    s_write(OFS_TX_PAY_3_4) |=> st_reg.tx_words[4] == $past(req_data_in)) else $error("word 4 not stored");
  a_word5_store: assert property (@(posedge clk_in) disable iff (reset_in)
    s_write(OFS_TX_PAY_5_6) |=> st_reg.tx_words[5] == $past(req_data_in)) else $error("word 5 not stored");
  a_word6_store: assert property (@(posedge clk_in) disable iff (reset_in)
    s_write(OFS_TX_PAY_7_8) |=> st_reg.tx_words[6] == $past(req_data_in)) else $error("word 6 not stored");
  a_byte_order: assert property (@(posedge clk_in) disable iff (reset_in)
    s_write(OFS_TX_PAY_1_2) |=> st_reg.tx_words[3][15:8] == $past(req_data_in[15:8])) else $error("byte order wrong");
  a_trigger_queues: assert property (@(posedge clk_in) disable iff (reset_in)
    s_trigger_free |=> st_reg.push_busy && st_reg.push_idx == 3'h0 && !resp_exc_out) else $error("trigger not queued");
  a_resend_keeps: assert property (@(posedge clk_in) disable iff (reset_in)
    s_write(OFS_TX_TRIGGER) |=> $stable(st_reg.tx_words)) else $error("trigger changed stored words");
  a_rx_match: assert property (@(posedge clk_in) disable iff (reset_in)
    rx_hit[0] |=> st_reg.slot_valid[0] && st_reg.slot_words[0][2] == $past(can_rx_id_in[15:0]))
    else $error("matched frame not stored");
  a_rx_latest: assert property (@(posedge clk_in) disable iff (reset_in)
    rx_hit[1] |=> st_reg.slot_words[1][6] == $past(can_rx_data_in[15:0])) else $error("slot not overwritten");
  a_read_first: assert property (@(posedge clk_in) disable iff (reset_in)
    take && req_func_in == FN_READ_INPUT && req_addr_in == SPEC_BASE && count_ok && !slot_empty
    |=> resp_valid_out && !resp_exc_out && resp_data_out == $past(st_reg.slot_words[0][0]) ##1 resp_valid_out)
    else $error("field read wrong");
  a_busy_overrun: assert property (@(posedge clk_in) disable iff (reset_in)
    s_write(OFS_TX_TRIGGER) ##0 st_reg.push_busy |=> resp_exc_out && resp_data_out == {8'h00, EXC_BUSY})
    else $error("overrun not refused");
endmodule : mwg_gateway
`default_nettype wire

// ==== mwg_pkg.sv ====
// constants shared by the word-to-frame gateway and its transmit queue
// assumes a single 125 MHz clock and a pre-decoded request port (no uart or crc here)
package mwg_pkg;
  // word layout
  localparam int WORD_W      = 16;
  localparam int TX_REGS     = 8;   // output words 0x0000..0x0007
  localparam int FRAME_WORDS = 7;   // words handed to the can controller per frame
  localparam int FIFO_DEPTH  = 16;
  localparam int SPEC_SLOTS  = 10;
  localparam int SLOT_WORDS  = 9;
  localparam int SPEC_WORDS  = SPEC_SLOTS * SLOT_WORDS;
  localparam int ID_W        = 29;
  // output word offsets
  localparam logic [15:0] OFS_TX_CONTROL = 16'h0000;
  localparam logic [15:0] OFS_TX_ID_HIGH = 16'h0001;
  localparam logic [15:0] OFS_TX_ID_LOW  = 16'h0002;
  localparam logic [15:0] OFS_TX_PAY_1_2 = 16'h0003;
  localparam logic [15:0] OFS_TX_PAY_3_4 = 16'h0004;
  localparam logic [15:0] OFS_TX_PAY_5_6 = 16'h0005;
  localparam logic [15:0] OFS_TX_PAY_7_8 = 16'h0006;
  localparam logic [15:0] OFS_TX_TRIGGER = 16'h0007;
  localparam logic [15:0] SPEC_BASE      = 16'h0800;
  localparam logic [15:0] TX_WORD_RESET  = 16'h0000;
  // function and exception codes
  localparam logic [7:0] FN_WRITE_SINGLE = 8'h06;
  localparam logic [7:0] FN_READ_INPUT   = 8'h04;
  localparam logic [7:0] EXC_ILL_FUNC    = 8'h01;
  localparam logic [7:0] EXC_ILL_ADDR    = 8'h02;
  localparam logic [7:0] EXC_ILL_VALUE   = 8'h03;
  localparam logic [7:0] EXC_BUSY        = 8'h06;
  // received control word fields
  localparam int CTRL_EXT_BIT = 5;
  localparam int CTRL_RTR_BIT = 4;
  // timestamp tick
  localparam int CLK_MHZ     = 125;
  localparam int TICK_US     = 1;
  localparam int TICK_CYCLES = CLK_MHZ * TICK_US;
endpackage : mwg_pkg

// ==== tb.sv ====
// self-checking bench for the word-to-frame gateway
// assumes mwg_pkg and the can stand-in model; clock 8 ns, sync reset
`timescale 1ns/1ps
`default_nettype none
module tb
  import mwg_pkg::*;
;
  logic                       clk_in = 1'b0;
  logic                       reset_in = 1'b1;
  logic                       req_valid_in = 1'b0;
  logic [7:0]                 req_func_in = 8'h00;
  logic [15:0]                req_addr_in = 16'h0000;
  logic [15:0]                req_data_in = 16'h0000;
  logic                       stall = 1'b0;
  logic [SPEC_SLOTS-1:0]      id_list_en_in = 10'h003;
  logic [SPEC_SLOTS-1:0]      id_list_ext_in = 10'h002;
  logic [SPEC_SLOTS*ID_W-1:0] id_list_in = '0;
  logic                       req_ready_out, resp_valid_out, resp_exc_out, resp_last_out;
  logic                       can_tx_valid_out, can_tx_ready_in, can_rx_valid_in, can_rx_ext_in, can_rx_rtr_in;
  logic [15:0]                resp_data_out, can_tx_data_out;
  logic [ID_W-1:0]            can_rx_id_in;
  logic [3:0]                 can_rx_dlc_in;
  logic [63:0]                can_rx_data_in;
  logic [15:0]                got[$], exp_tx[$];
  logic [15:0]                tw[TX_REGS] = '{default: 16'h0000};
  logic [15:0]                slot_w[SPEC_SLOTS][7];
  logic                       last_exc;
  int                         n_fail = 0;
  int                         compares = 0;
  // refused requests: function, address, value, expected code
  localparam logic [7:0]  BAD_F[6] = '{8'h06, 8'h03, 8'h10, 8'h04, 8'h04, 8'h04};
  localparam logic [15:0] BAD_A[6] = '{16'h0008, 16'h0000, 16'h0000, 16'h0801, 16'h0800, 16'h0800};
  localparam logic [15:0] BAD_D[6] = '{16'h1234, 16'h0007, 16'h0007, 16'h0009, 16'h000a, 16'h0063};
  localparam logic [7:0]  BAD_C[6] = '{EXC_ILL_ADDR, EXC_ILL_FUNC, EXC_ILL_FUNC, EXC_ILL_ADDR, EXC_ILL_VALUE,
                                       EXC_ILL_VALUE};

  always #4 clk_in = ~clk_in;

  mwg_gateway uut (.clk_in(clk_in), .reset_in(reset_in), .req_valid_in(req_valid_in), .req_func_in(req_func_in),
    .req_addr_in(req_addr_in), .req_data_in(req_data_in), .req_ready_out(req_ready_out),
    .resp_valid_out(resp_valid_out), .resp_exc_out(resp_exc_out), .resp_last_out(resp_last_out),
    .resp_data_out(resp_data_out), .can_tx_valid_out(can_tx_valid_out), .can_tx_data_out(can_tx_data_out),
    .can_tx_ready_in(can_tx_ready_in), .can_rx_valid_in(can_rx_valid_in), .can_rx_id_in(can_rx_id_in),
    .can_rx_ext_in(can_rx_ext_in), .can_rx_rtr_in(can_rx_rtr_in), .can_rx_dlc_in(can_rx_dlc_in),
    .can_rx_data_in(can_rx_data_in), .id_list_en_in(id_list_en_in), .id_list_ext_in(id_list_ext_in),
    .id_list_in(id_list_in));

  mwg_can_model can (.clk_in(clk_in), .tx_valid_in(can_tx_valid_out), .tx_data_in(can_tx_data_out),
    .tx_ready_out(can_tx_ready_in), .stall_in(stall), .rx_valid_out(can_rx_valid_in), .rx_id_out(can_rx_id_in),
    .rx_ext_out(can_rx_ext_in), .rx_rtr_out(can_rx_rtr_in), .rx_dlc_out(can_rx_dlc_in),
    .rx_data_out(can_rx_data_in));

  task automatic print_verdict();
    if (n_fail == 0 && compares > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask : print_verdict

  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    compares++;
    if (seen !== exp) begin
      n_fail++;
      $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : check

  // request held until taken, then every answer word gathered up to the last one
  task automatic req(input logic [7:0] f, input logic [15:0] a, input logic [15:0] d);
    int k;
    got.delete();
    @(posedge clk_in);
    #1;
    {req_valid_in, req_func_in, req_addr_in, req_data_in} = {1'b1, f, a, d};
    for (k = 0; req_ready_out !== 1'b1 && k < 50; k++) @(posedge clk_in) #1;
    check({15'h0000, req_ready_out}, 16'h0001);
    @(posedge clk_in);
    #1;
    req_valid_in = 1'b0;
    for (k = 0; k < 100; k++) begin
      if (resp_valid_out === 1'b1) begin
        got.push_back(resp_data_out);
        last_exc = resp_exc_out;
        if (resp_last_out === 1'b1) break;
      end
      @(posedge clk_in) #1;
    end
    check({15'h0000, resp_last_out}, 16'h0001);
  endtask : req

  task automatic exc_chk(input logic [7:0] code);
    check({15'h0000, last_exc}, 16'h0001);
    check({8'h00, got[0][7:0]}, {8'h00, code});
  endtask : exc_chk

  // write with echo; the trigger word queues the seven stored words
  task automatic wr(input logic [15:0] a, input logic [15:0] d);
    req(FN_WRITE_SINGLE, a, d);
    check(got[0], d);
    check({15'h0000, last_exc}, 16'h0000);
    if (a < OFS_TX_TRIGGER) tw[a[2:0]] = d;
    else for (int i = 0; i < FRAME_WORDS; i++) exp_tx.push_back(tw[i]);
  endtask : wr

  // bench-side match against the enabled list decides which slot takes the frame
  task automatic rx(input logic [28:0] id, input logic ext);
    logic [63:0] d;
    logic [3:0]  dlc;
    logic        rtr;
    d = {$urandom, $urandom};
    dlc = 4'($urandom % 9);
    rtr = 1'($urandom);
    for (int g = 0; g < SPEC_SLOTS; g++)
      if (id_list_en_in[g] && id_list_in[g*ID_W +: ID_W] === id && id_list_ext_in[g] === ext)
        slot_w[g] = '{{10'h000, ext, rtr, dlc}, {3'b000, id[28:16]}, id[15:0], d[63:48], d[47:32], d[31:16],
                      d[15:0]};
    can.send(id, ext, rtr, dlc, d);
  endtask : rx

  // timestamp words are free-running and left unchecked
  task automatic rd_chk(input int n);
    req(FN_READ_INPUT, SPEC_BASE, 16'(n * SLOT_WORDS));
    check(16'(got.size()), 16'(n * SLOT_WORDS));
    for (int k = 0; k < n * SLOT_WORDS; k++)
      if (k % SLOT_WORDS < 7) check(got[k], slot_w[k / SLOT_WORDS][k % SLOT_WORDS]);
  endtask : rd_chk

  task automatic drain_chk();
    int k;
    for (k = 0; can.seen.size() < exp_tx.size() && k < 2000; k++) @(posedge clk_in);
    check(16'(can.seen.size()), 16'(exp_tx.size()));
    foreach (exp_tx[i]) check(can.seen[i], exp_tx[i]);
    repeat (4) @(posedge clk_in);
    #1;
    check({15'h0000, can_tx_valid_out}, 16'h0000);
    can.seen.delete();
    exp_tx.delete();
  endtask : drain_chk

  // main sequence
  initial begin
    void'($urandom(32'h0eaa));
    id_list_in[ID_W-1:0] = {18'h00000, 11'($urandom)};
    id_list_in[2*ID_W-1:ID_W] = 29'($urandom);
    repeat (4) @(posedge clk_in);
    #1;
    reset_in = 1'b0;
    check({15'h0000, req_ready_out}, 16'h0001);
    for (int i = 0; i < TX_REGS; i++) wr(16'(i), 16'($urandom));
    repeat (12) @(posedge clk_in);
    wr(OFS_TX_TRIGGER, 16'h0001);
    req(FN_WRITE_SINGLE, OFS_TX_TRIGGER, 16'h0002);
    exc_chk(EXC_BUSY);
    repeat (12) @(posedge clk_in);
    wr(OFS_TX_PAY_5_6, 16'($urandom));
    wr(OFS_TX_TRIGGER, 16'h0003);
    foreach (BAD_F[i]) begin
      req(BAD_F[i], BAD_A[i], BAD_D[i]);
      exc_chk(BAD_C[i]);
    end
    drain_chk();
    // stalled drain: third frame overfills the queue, fourth trigger is refused
    stall = 1'b1;
    for (int i = 0; i < 3; i++) begin
      wr(OFS_TX_TRIGGER, 16'(i));
      repeat (10) @(posedge clk_in);
    end
    req(FN_WRITE_SINGLE, OFS_TX_TRIGGER, 16'h00ff);
    exc_chk(EXC_BUSY);
    check({15'h0000, can_tx_valid_out}, 16'h0001);
    stall = 1'b0;
    drain_chk();
    // specific-message field
    req(FN_READ_INPUT, SPEC_BASE, 16'h0009);
    exc_chk(EXC_BUSY);
    rx(id_list_in[ID_W-1:0], 1'b0);
    rd_chk(1);
    rx(id_list_in[ID_W-1:0], 1'b1);
    rx(id_list_in[2*ID_W-1:ID_W], 1'b1);
    rx(id_list_in[ID_W-1:0], 1'b0);
    rd_chk(2);
    req(FN_READ_INPUT, SPEC_BASE, 16'h001b);
    exc_chk(EXC_BUSY);
    print_verdict();
  end

  // watchdog: tests need well under 5000 cycles
  initial begin
    #200000;
    n_fail++;
    print_verdict();
  end
endmodule : tb
`default_nettype wire
